/* File: logic/has_params.svh */
// Offsets, field positions, reset values and timing counts of the activation block
`ifndef HAS_PARAMS_SVH
`define HAS_PARAMS_SVH

`define HAS_CLK_HZ 25000000
`define HAS_MS_CYCLES (`HAS_CLK_HZ / 1000)

`define HAS_LOST_S 1
`define HAS_SYNC_LOSS_S 2
`define HAS_ACT_S 30
`define HAS_FRAMER_S 1
`define HAS_LOST_MS 16'(`HAS_LOST_S * 1000)
`define HAS_SYNC_LOSS_MS 16'(`HAS_SYNC_LOSS_S * 1000)
`define HAS_ACT_MS 16'(`HAS_ACT_S * 1000)
`define HAS_FRAMER_MS 16'(`HAS_FRAMER_S * 1000)

`define HAS_OFF_CTRL 4'h0
`define HAS_OFF_STAT 4'h1
`define HAS_OFF_SYNC 4'h2

`define HAS_CTRL_REQ_BIT 0
`define HAS_CTRL_QUIET_BIT 1
`define HAS_CTRL_REMOTE_BIT 2
`define HAS_CTRL_RESTART_BIT 3
`define HAS_CTRL_RESET 3'h0

`endif

/* File: logic/has_pkg.sv */
// Types shared by the activation and frame-sync block
package has_pkg;

  typedef enum logic [2:0] {
    HAS_DP_INACTIVE = 3'b000,
    HAS_DP_ACTIVATING = 3'b001,
    HAS_DP_ACTIVE1 = 3'b010,
    HAS_DP_ACTIVE2 = 3'b011,
    HAS_DP_PENDING = 3'b100,
    HAS_DP_DEACTIVATED = 3'b101
  } has_pump_t;

  typedef enum logic [1:0] {
    HAS_FR_IDLE = 2'b00,
    HAS_FR_ACTIVE_R = 2'b01,
    HAS_FR_ACTIVE_T = 2'b10,
    HAS_FR_LINK = 2'b11
  } has_framer_t;

  typedef enum logic [3:0] {
    HAS_SY_S0 = 4'h0, HAS_SY_S1 = 4'h1, HAS_SY_S2 = 4'h2, HAS_SY_S3 = 4'h3,
    HAS_SY_S4 = 4'h4, HAS_SY_S5 = 4'h5, HAS_SY_S6 = 4'h6, HAS_SY_S7 = 4'h7,
    HAS_SY_S8 = 4'h8, HAS_SY_S9 = 4'h9, HAS_SY_S10 = 4'hA
  } has_sync_t;

  typedef struct packed {
    logic frame_tick;
    logic sync_match;
    logic alignment_shift;
    logic signal_energy;
    logic signal_absent;
    logic snr_ok;
    logic ind_rx;
    logic rx_payload;
  } has_line_in_t;

  typedef struct packed {
    logic tx_line;
    logic ind_tx;
  } has_line_out_t;

endpackage

/* File: logic/has_activation_sync.sv */
// Activation and frame-sync control for one HDSL line unit, central or remote role
//
// Contract
// - Idle to Link Active only after indicator exchange or remote timeout
// - Central SNR reached: set flag, enter Active-R
// - Central receives remote bit: enter Active-T
// - Central partial to Link Active needs both bits
// - Active framer states open duplex link
// - Payload transmission only Active or Pending
// - Receive payload High outside Active-1/Active-2
// - Central leaves Inactive on request; remote on energy
// - Central De-Activated to Inactive after 1 s
// - Remote De-Activated to Inactive on signal loss
// - Remote: own flag Active-R, central bit Active-T
// - Remote partial to Link on bit or timeout
// - Two matches reach in-sync State 2
// - Six mismatches from sync reach State 8
// - State 8 to State 0 on timeout/loss
// - Unchanged alignment returns through State 9
// - Changed alignment returns through State 10
// - Sync states map onto pump states
// - Pump state reported as 3-bit code
// - Transmit passes only in codes 010/011/100
`timescale 1ns/1ns
`include "has_params.svh"

module has_activation_sync
  import has_pkg::*;
#(
  parameter int MS_CYCLES = `HAS_MS_CYCLES
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire has_line_in_t line_in,
  output has_line_out_t line_out,
  input wire logic tx_payload,
  output logic rx_payload,
  output logic link_open,
  output logic active,
  output logic [2:0] activation_state_code
);

  logic [15:0] ms_cnt_r;
  logic ms_tick_r;
  logic ctrl_act_req_r;
  logic ctrl_quiet_r;
  logic ctrl_remote_r;
  logic restart_r;
  logic act_req_d_r;
  logic quiet_d_r;
  logic act_rise;
  logic quiet_rise;
  has_pump_t pump_r;
  has_pump_t pump_nxt;
  has_pump_t pend_from_r;
  logic [15:0] pump_tmr_r;
  has_sync_t sync_r;
  has_sync_t sync_nxt;
  logic [15:0] sync_tmr_r;
  logic sync_timeout;
  has_framer_t fr_r;
  has_framer_t fr_nxt;
  logic [15:0] fr_tmr_r;
  logic own_ind_r;
  logic far_ind_r;
  logic framer_run;
  logic [7:0] rdata_r;
  has_line_out_t line_out_r;
  logic rx_payload_r;
  logic link_open_r;
  logic active_r;
  logic [2:0] code_r;

  // Millisecond enable keeps all second-scale timers at 16 bits
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ms_cnt_r <= 16'h0000;
      ms_tick_r <= 1'b0;
    end else if (ms_cnt_r == 16'(MS_CYCLES - 1)) begin
      ms_cnt_r <= 16'h0000;
      ms_tick_r <= 1'b1;
    end else begin
      ms_cnt_r <= ms_cnt_r + 16'h0001;
      ms_tick_r <= 1'b0;
    end
  end

  // Control register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_act_req_r <= 1'b0;
      ctrl_quiet_r <= 1'b0;
      ctrl_remote_r <= 1'b0;
      restart_r <= 1'b0;
    end else begin
      restart_r <= 1'b0;
      if (reg_wr && reg_addr == `HAS_OFF_CTRL) begin
        ctrl_act_req_r <= reg_wdata[`HAS_CTRL_REQ_BIT];
        ctrl_quiet_r <= reg_wdata[`HAS_CTRL_QUIET_BIT];
        ctrl_remote_r <= reg_wdata[`HAS_CTRL_REMOTE_BIT];
        restart_r <= reg_wdata[`HAS_CTRL_RESTART_BIT];
      end
    end
  end

  // Request is a level; only its rising edge starts one activation
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      act_req_d_r <= 1'b0;
      quiet_d_r <= 1'b0;
    end else begin
      act_req_d_r <= ctrl_act_req_r;
      quiet_d_r <= ctrl_quiet_r;
    end
  end

  assign act_rise = ctrl_act_req_r & ~act_req_d_r;
  assign quiet_rise = ctrl_quiet_r & ~quiet_d_r;

  // Frame-sync machine, stepped by received frame timing
  always_comb begin
    sync_nxt = sync_r;
    if (line_in.frame_tick) begin
      case (sync_r)
        HAS_SY_S0: sync_nxt = line_in.sync_match ? HAS_SY_S1 : HAS_SY_S0;
        HAS_SY_S1: sync_nxt = line_in.sync_match ? HAS_SY_S2 : HAS_SY_S0;
        HAS_SY_S2, HAS_SY_S3, HAS_SY_S4, HAS_SY_S5, HAS_SY_S6, HAS_SY_S7: begin
          sync_nxt = line_in.sync_match ? HAS_SY_S2 : has_sync_t'(sync_r + 4'h1);
        end
        HAS_SY_S8: begin
          if (line_in.sync_match) begin
            sync_nxt = line_in.alignment_shift ? HAS_SY_S10 : HAS_SY_S9;
          end
        end
        HAS_SY_S9: begin
          sync_nxt = (line_in.sync_match && !line_in.alignment_shift) ?
                     HAS_SY_S2 : HAS_SY_S8;
        end
        HAS_SY_S10: sync_nxt = line_in.sync_match ? HAS_SY_S2 : HAS_SY_S8;
        default: sync_nxt = HAS_SY_S0;
      endcase
    end
    if (sync_r >= HAS_SY_S8 && (sync_timeout || line_in.signal_absent)) begin
      sync_nxt = HAS_SY_S0;
    end
    if (pump_r == HAS_DP_INACTIVE || pump_r == HAS_DP_DEACTIVATED || restart_r) begin
      sync_nxt = HAS_SY_S0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sync_r <= HAS_SY_S0;
    end else begin
      sync_r <= sync_nxt;
    end
  end

  // Sync-loss timer runs only while out of sync after losing it
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sync_tmr_r <= 16'h0000;
    end else if (sync_r < HAS_SY_S8) begin
      sync_tmr_r <= 16'h0000;
    end else if (ms_tick_r && !sync_timeout) begin
      sync_tmr_r <= sync_tmr_r + 16'h0001;
    end
  end

  assign sync_timeout = (sync_tmr_r >= `HAS_SYNC_LOSS_MS);

  // Data-pump activation machine, driven by the sync state
  always_comb begin
    pump_nxt = pump_r;
    case (pump_r)
      HAS_DP_INACTIVE: begin
        if (ctrl_remote_r ? line_in.signal_energy : (act_rise && !ctrl_quiet_r)) begin
          pump_nxt = HAS_DP_ACTIVATING;
        end
      end
      HAS_DP_ACTIVATING: begin
        if (sync_r == HAS_SY_S2) begin
          pump_nxt = HAS_DP_ACTIVE1;
        end else if (pump_tmr_r >= `HAS_ACT_MS) begin
          pump_nxt = HAS_DP_DEACTIVATED;
        end
      end
      HAS_DP_ACTIVE1, HAS_DP_ACTIVE2: begin
        if (quiet_rise) begin
          pump_nxt = HAS_DP_DEACTIVATED;
        end else if (sync_r == HAS_SY_S8) begin
          pump_nxt = HAS_DP_PENDING;
        end else if (pump_r == HAS_DP_ACTIVE1 && pump_tmr_r >= `HAS_ACT_MS) begin
          pump_nxt = HAS_DP_ACTIVE2;
        end
      end
      HAS_DP_PENDING: begin
        if (sync_r == HAS_SY_S2) begin
          pump_nxt = pend_from_r;
        end else if (sync_r == HAS_SY_S0) begin
          pump_nxt = HAS_DP_DEACTIVATED;
        end
      end
      HAS_DP_DEACTIVATED: begin
        if (ctrl_remote_r) begin
          if (line_in.signal_absent) begin
            pump_nxt = HAS_DP_INACTIVE;
          end
        end else if (line_in.signal_absent && pump_tmr_r >= `HAS_LOST_MS) begin
          pump_nxt = HAS_DP_INACTIVE;
        end
      end
      default: pump_nxt = HAS_DP_INACTIVE;
    endcase
    if (restart_r) begin
      pump_nxt = HAS_DP_INACTIVE;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pump_r <= HAS_DP_INACTIVE;
      pend_from_r <= HAS_DP_ACTIVE1;
    end else begin
      pump_r <= pump_nxt;
      if (pump_nxt == HAS_DP_PENDING && pump_r != HAS_DP_PENDING) begin
        pend_from_r <= pump_r;
      end
    end
  end

  // State timer; in De-Activated it measures continuous signal absence
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pump_tmr_r <= 16'h0000;
    end else if (pump_nxt != pump_r) begin
      pump_tmr_r <= 16'h0000;
    end else if (pump_r == HAS_DP_DEACTIVATED && !line_in.signal_absent) begin
      pump_tmr_r <= 16'h0000;
    end else if (ms_tick_r && pump_tmr_r != 16'hFFFF) begin
      pump_tmr_r <= pump_tmr_r + 16'h0001;
    end
  end

  // Framer runs only once the pump is in sync
  assign framer_run = (pump_r == HAS_DP_ACTIVE1) || (pump_r == HAS_DP_ACTIVE2) ||
                      (pump_r == HAS_DP_PENDING);

  // Own flag is the central bit as central unit, the remote bit as remote
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      own_ind_r <= 1'b0;
      far_ind_r <= 1'b0;
    end else if (!framer_run || restart_r) begin
      own_ind_r <= 1'b0;
      far_ind_r <= 1'b0;
    end else begin
      if (line_in.snr_ok) begin
        own_ind_r <= 1'b1;
      end
      if (line_in.ind_rx) begin
        far_ind_r <= 1'b1;
      end
    end
  end

  always_comb begin
    fr_nxt = fr_r;
    case (fr_r)
      HAS_FR_IDLE: begin
        if (own_ind_r) begin
          fr_nxt = HAS_FR_ACTIVE_R;
        end else if (far_ind_r) begin
          fr_nxt = HAS_FR_ACTIVE_T;
        end
      end
      HAS_FR_ACTIVE_R, HAS_FR_ACTIVE_T: begin
        if (own_ind_r && far_ind_r) begin
          fr_nxt = HAS_FR_LINK;
        end else if (ctrl_remote_r && fr_tmr_r >= `HAS_FRAMER_MS) begin
          fr_nxt = HAS_FR_LINK;
        end
      end
      HAS_FR_LINK: fr_nxt = HAS_FR_LINK;
      default: fr_nxt = HAS_FR_IDLE;
    endcase
    if (!framer_run || restart_r) begin
      fr_nxt = HAS_FR_IDLE;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fr_r <= HAS_FR_IDLE;
    end else begin
      fr_r <= fr_nxt;
    end
  end

  // Partial-state timer, only consulted in the remote role
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fr_tmr_r <= 16'h0000;
    end else if (fr_nxt != fr_r) begin
      fr_tmr_r <= 16'h0000;
    end else if (ms_tick_r && fr_tmr_r != 16'hFFFF) begin
      fr_tmr_r <= fr_tmr_r + 16'h0001;
    end
  end

  // Line-facing and status outputs, all registered
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      line_out_r <= '0;
      rx_payload_r <= 1'b1;
      link_open_r <= 1'b0;
      active_r <= 1'b0;
      code_r <= HAS_DP_INACTIVE;
    end else begin
      // Outside transparent states the line is held at a constant one
      line_out_r.tx_line <= (pump_r == HAS_DP_ACTIVE1 || pump_r == HAS_DP_ACTIVE2 ||
                             pump_r == HAS_DP_PENDING) ? tx_payload : 1'b1;
      line_out_r.ind_tx <= own_ind_r;
      rx_payload_r <= (pump_r == HAS_DP_ACTIVE1 || pump_r == HAS_DP_ACTIVE2) ?
                      line_in.rx_payload : 1'b1;
      link_open_r <= (fr_r != HAS_FR_IDLE);
      active_r <= (pump_r == HAS_DP_ACTIVE1 || pump_r == HAS_DP_ACTIVE2);
      code_r <= pump_r;
    end
  end

  // Register reads; unmapped offsets read zero
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `HAS_OFF_CTRL: rdata_r <= {5'h00, ctrl_remote_r, ctrl_quiet_r, ctrl_act_req_r};
        `HAS_OFF_STAT: rdata_r <= {1'b0, far_ind_r, own_ind_r, fr_r, pump_r};
        `HAS_OFF_SYNC: rdata_r <= {4'h0, sync_r};
        default: rdata_r <= 8'h00;
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end

  assign reg_rdata = rdata_r;
  assign line_out = line_out_r;
  assign rx_payload = rx_payload_r;
  assign link_open = link_open_r;
  assign active = active_r;
  assign activation_state_code = code_r;

endmodule

/* File: test/has_activation_sync_assertions.sv */
// Port checker for the activation and frame-sync block
`timescale 1ns/1ns
module has_activation_sync_assertions
  import has_pkg::*;
#(
  parameter int MS_CYCLES = 25000
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire has_line_in_t line_in,
  input wire has_line_out_t line_out,
  input wire logic tx_payload,
  input wire logic rx_payload,
  input wire logic link_open,
  input wire logic active,
  input wire logic [2:0] activation_state_code
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  logic rx_on;
  logic tx_on;
  assign rx_on = activation_state_code inside {3'h2, 3'h3};
  assign tx_on = activation_state_code inside {3'h2, 3'h3, 3'h4};
  AST_RX_CLAMP: assert property (!rx_on && !$past(rx_on) |-> rx_payload)
    else $error("receive payload not held high");
  AST_RX_PASS: assert property (rx_on && $past(rx_on)
    |-> rx_payload == $past(line_in.rx_payload))
    else $error("receive payload not passed");
  AST_TX_CLAMP: assert property ($past(rst_n) && !tx_on && !$past(tx_on)
    |-> line_out.tx_line)
    else $error("line output not idle high");
  AST_TX_PASS: assert property ($past(rst_n) && tx_on && $past(tx_on)
    |-> line_out.tx_line == $past(tx_payload))
    else $error("transmit payload not passed");
  AST_CODE_LEGAL: assert property (!(activation_state_code inside {3'h6, 3'h7}))
    else $error("unused state code");
  AST_FROM_IDLE: assert property ($past(activation_state_code) == 3'h0
    |-> activation_state_code inside {3'h0, 3'h1})
    else $error("inactive left to wrong state");
  AST_FRAMER_IDLE: assert property ((!tx_on) [*3] |-> !link_open && !line_out.ind_tx)
    else $error("link or flag up while pump idle");
  AST_SYNC_RD: assert property ($past(reg_rd) && $past(reg_addr) == 4'h2
    |-> reg_rdata <= 8'h0A)
    else $error("sync state out of range");
endmodule

bind has_activation_sync has_activation_sync_assertions #(.MS_CYCLES(MS_CYCLES)) u_chk (
  .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .line_in(line_in),
  .line_out(line_out), .tx_payload(tx_payload), .rx_payload(rx_payload),
  .link_open(link_open), .active(active), .activation_state_code(activation_state_code));

/* File: test/has_far_end.sv */
// Far-end unit and line model feeding the receive side of the block
`timescale 1ns/1ns
module has_far_end
  import has_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic match,
  input wire logic shift,
  input wire logic energy,
  input wire logic absent,
  input wire logic snr,
  input wire logic ind,
  output has_line_in_t line
);
  int gap_r;
  logic ind_r;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      gap_r <= 3;
      ind_r <= 1'b0;
      line <= '0;
    end else begin
      line.frame_tick <= energy && gap_r == 0;
      // Off-frame qualifiers toggle so a stale value never looks valid
      line.sync_match <= (gap_r == 0) ? match : ~line.sync_match;
      line.alignment_shift <= (gap_r == 0) ? shift : ~line.alignment_shift;
      line.signal_energy <= energy;
      line.signal_absent <= absent;
      line.snr_ok <= snr;
      line.rx_payload <= 1'($urandom);
      // Indicator rides in frame overhead, so it only moves at frame edges
      if (gap_r == 0) ind_r <= ind;
      line.ind_rx <= ind_r;
      gap_r <= (gap_r == 0) ? 3 + int'($urandom % 7) : gap_r - 1;
    end
  end
endmodule

/* File: test/tb.sv */
// Bench for the activation block with a frame-sync reference model
`timescale 1ns/1ns
module tb
  import has_pkg::*;
;
  logic mclk, rst_n, reg_wr, reg_rd, tx_payload;
  logic match, shift, energy, absent, snr, ind;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, d;
  logic rx_payload, link_open, active;
  logic [2:0] code;
  has_line_in_t line_in;
  has_line_out_t line_out;
  int err_total, n_compared, sync_m;
  has_activation_sync #(.MS_CYCLES(10)) u_dut (.mclk(mclk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .line_in(line_in), .line_out(line_out),
    .tx_payload(tx_payload), .rx_payload(rx_payload), .link_open(link_open),
    .active(active), .activation_state_code(code));
  has_far_end u_far (.mclk(mclk), .rst_n(rst_n), .match(match), .shift(shift),
    .energy(energy), .absent(absent), .snr(snr), .ind(ind), .line(line_in));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) tx_payload <= 1'($urandom);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic poll(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m,
                      input int lim);
    logic [7:0] v;
    for (int i = 0; i < lim; i++) begin
      rd(a, v);
      if ((v & m) === e) break;
    end
    chk(v & m, e);
    if ((v & m) !== e) results();
  endtask
  function automatic int step(input int s, input logic m, input logic sh);
    if (s == 8) return m ? (sh ? 10 : 9) : 8;
    if (s == 9) return (m && !sh) ? 2 : 8;
    if (s == 10) return m ? 2 : 8;
    if (s >= 2) return m ? 2 : s + 1;
    return m ? s + 1 : 0;
  endfunction
  // First frame still carries the old qualifiers; every frame is modelled
  task automatic frames(input int n, input logic m, input logic sh);
    int j;
    logic [7:0] v;
    for (int k = 0; k <= n; k++) begin
      j = 0;
      do begin
        @(posedge mclk);
        j++;
      end while (!line_in.frame_tick && j < 40);
      chk(8'(j < 40), 8'h01);
      if (j >= 40) results();
      sync_m = step(sync_m, match, shift);
      if (k == 0) begin
        match <= m;
        shift <= sh;
      end
      rd(4'h2, v);
      chk(v, 8'(sync_m));
    end
  endtask
  initial begin
    void'($urandom(32'h36E2));
    {rst_n, reg_wr, reg_rd, match, shift, energy, absent, snr, ind} = '0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    err_total = 0;
    n_compared = 0;
    sync_m = 0;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    for (int a = 0; a < 4; a++) begin
      rd(4'(a), d);
      chk(d, 8'h00);
    end
    wr(4'hF, 8'($urandom));
    rd(4'hF, d);
    chk(d, 8'h00);
    @(posedge mclk);
    energy <= 1'b1;
    repeat (30) @(posedge mclk);
    chk(8'(code), 8'h00);
    wr(4'h0, 8'h01);
    poll(4'h1, 8'h01, 8'h07, 50);
    frames(2, 1'b1, 1'b0);
    poll(4'h1, 8'h02, 8'h07, 50);
    chk(8'(active), 8'h01);
    @(posedge mclk);
    ind <= 1'b1;
    poll(4'h1, 8'h52, 8'hFF, 50);
    @(posedge mclk);
    snr <= 1'b1;
    poll(4'h1, 8'h7A, 8'hFF, 50);
    chk(8'(line_out.ind_tx), 8'h01);
    chk(8'(link_open), 8'h01);
    frames(5, 1'b0, 1'b0);
    chk(8'(code), 8'h02);
    frames(1, 1'b0, 1'b0);
    poll(4'h1, 8'h04, 8'h07, 50);
    frames(2, 1'b1, 1'b0);
    poll(4'h1, 8'h02, 8'h07, 50);
    frames(6, 1'b0, 1'b0);
    frames(2, 1'b1, 1'b1);
    poll(4'h1, 8'h02, 8'h07, 50);
    frames(6, 1'b0, 1'b0);
    @(posedge mclk);
    absent <= 1'b1;
    poll(4'h2, 8'h00, 8'hFF, 50);
    sync_m = 0;
    poll(4'h1, 8'h05, 8'h07, 50);
    repeat (9000) @(posedge mclk);
    chk(8'(code), 8'h05);
    poll(4'h1, 8'h00, 8'h07, 2000);
    @(posedge mclk);
    {energy, absent, snr, ind} <= 4'h0;
    wr(4'h0, 8'h04);
    repeat (20) @(posedge mclk);
    chk(8'(code), 8'h00);
    @(posedge mclk);
    energy <= 1'b1;
    poll(4'h1, 8'h01, 8'h07, 50);
    frames(2, 1'b1, 1'b0);
    @(posedge mclk);
    snr <= 1'b1;
    poll(4'h1, 8'h2A, 8'hFF, 50);
    poll(4'h1, 8'h3A, 8'hFF, 6000);
    // Restart drops framer and flags; energy brings the remote unit back up
    wr(4'h0, 8'h0C);
    poll(4'h1, 8'h01, 8'hFF, 50);
    poll(4'h1, 8'h2A, 8'hFF, 50);
    wr(4'h0, 8'h06);
    poll(4'h1, 8'h05, 8'h07, 50);
    @(posedge mclk);
    {energy, absent} <= 2'b01;
    poll(4'h1, 8'h00, 8'h07, 20);
    results();
  end
endmodule
